// [dv/tb_top.sv]
`timescale 1ns/1ns
`include "usb_ep_irq_cfg.svh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, usb_irq, sof_irq, sof_pid_seen, sof_done, sof_crc_ok;
  logic [10:0] sof_frame;
  logic [29:0] endpoint_sources = 0;
  int n_mismatch = 0, n_tests = 0;
  always #50 pclk = ~pclk;
  usb_endpoint_irq_frame_number uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .endpoint_sources, .sof_pid_seen, .sof_done,
    .sof_crc_ok, .sof_frame, .usb_irq, .sof_irq);
  usb_host_sof host (.pclk, .sof_pid_seen, .sof_done, .sof_crc_ok, .sof_frame);
  task automatic chk(input string s, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= `IDX_TO_ADDR(i);
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), rd, e);
  endtask : rdc
  task automatic t_reset;
    byte unsigned ix[5] = '{8'hba, 8'hbb, 8'hf8, 8'hf9, 8'h10};
    foreach (ix[i]) rdc(ix[i], 32'h0);
  endtask : t_reset
  task automatic t_ep;
    for (int b = 0; b < 30; b++) begin
      endpoint_sources <= 30'h1 << b;
      apb(1'b1, 8'hf9, 32'h1 << b / 5);
      apb(1'b1, 8'hf8, 32'h0);
      rdc(8'hf8, 32'h1 << b / 5);
      chk("irq", usb_irq, 32'h1);
      apb(1'b1, 8'hf9, 32'h3f ^ (32'h1 << b / 5));
      chk("irq", usb_irq, 32'h0);
      endpoint_sources <= 30'h0;
      apb(1'b1, 8'hf9, 32'h3f);
      chk("irq", usb_irq, 32'h0);
    end
    rdc(8'hf9, 32'h3f);
  endtask : t_ep
  task automatic t_sof;
    apb(1'b1, 8'hfb, 32'h1);
    host.send(11'h5a5, 1'b1);
    chk("sof irq", sof_irq, 32'h1);
    rdc(8'hfa, 32'h3);
    apb(1'b1, 8'hba, 32'hff);
    apb(1'b1, 8'hbb, 32'hff);
    rdc(8'hba, 32'ha5);
    rdc(8'hbb, 32'h25);
    host.send(11'h123, 1'b0);
    rdc(8'hba, 32'h23);
    rdc(8'hbb, 32'h11);
  endtask : t_sof
  task automatic conclude;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ep();
    t_sof();
    conclude();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule : tb_top

// [dv/usb_ep_irq_asserts.sv]
`timescale 1ns/1ns
module usb_ep_irq_chk #(parameter int NUM_EP = 6, parameter int NUM_SRC = 5) (
  input wire logic                      pclk,             // clock
  input wire logic                      presetn,          // reset
  input wire logic                      psel,             // select
  input wire logic                      penable,          // access
  input wire logic                      pwrite,           // write
  input wire logic [31:0]               paddr,            // address
  input wire logic [31:0]               prdata,           // read data
  input wire logic                      pready,           // ready
  input wire logic                      pslverr,          // error
  input wire logic [NUM_EP*NUM_SRC-1:0] endpoint_sources, // sources
  input wire logic                      usb_irq           // irq
);
  logic [NUM_EP-1:0] any;
  always_comb for (int i = 0; i < NUM_EP; i++) any[i] = |endpoint_sources[NUM_SRC*i+:NUM_SRC];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_pls; pready |=> !pready; endproperty
  a_pls: assert property (p_pls) else $error("ready too long");
  property p_idle; !pready |-> prdata == 0; endproperty
  a_idle: assert property (p_idle) else $error("data without ready");
  property p_low; endpoint_sources == 0 |=> !usb_irq; endproperty
  a_low: assert property (p_low) else $error("irq without flag");
  property p_flg; pready && !pwrite && paddr == 32'h3e0 |-> prdata == $past(any, 2); endproperty
  a_flg: assert property (p_flg) else $error("flags wrong");
  property p_hi; pready && !pwrite && paddr == 32'h2ec |->
    prdata[31:6] == 0 && !prdata[3] && !(prdata[5] && prdata[4]); endproperty
  a_hi: assert property (p_hi) else $error("frame high wrong");
  property p_en; pready && !pwrite && paddr == 32'h3e4 |-> prdata[31:6] == 0; endproperty
  a_en: assert property (p_en) else $error("enables wrong");
  property p_err; pready |->
    pslverr == !(paddr inside {32'h2e8, 32'h2ec, [32'h3e0:32'h3ec]}); endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
endmodule : usb_ep_irq_chk
bind usb_endpoint_irq_frame_number usb_ep_irq_chk #(.NUM_EP(NUM_EP), .NUM_SRC(NUM_SRC)) chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .endpoint_sources, .usb_irq);

// [dv/usb_host_sof.sv]
`timescale 1ns/1ns
module usb_host_sof (
  input wire logic pclk,         // clock
  output logic     sof_pid_seen, // pid pulse
  output logic     sof_done,     // check pulse
  output logic     sof_crc_ok,   // crc result
  output logic [10:0] sof_frame  // frame number
);
  initial {sof_pid_seen, sof_done, sof_crc_ok, sof_frame} = '0;
  task automatic send(input logic [10:0] f, input logic ok);
    @(posedge pclk) sof_pid_seen <= 1'b1;
    @(posedge pclk) sof_pid_seen <= 1'b0;
    repeat (3) @(posedge pclk);
    sof_done <= 1'b1;
    sof_frame <= f;
    sof_crc_ok <= ok;
    @(posedge pclk) sof_done <= 1'b0;
    // data no longer valid: show inverse
    sof_frame <= ~f;
    sof_crc_ok <= !ok;
  endtask : send
endmodule : usb_host_sof

// [rtl/usb_endpoint_irq_frame_number.sv]
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "usb_ep_irq_cfg.svh"
// Contract
// - each of endpoints 0..5 has a flag set by hardware when any of its sources is seen.
// - the sources of a flag are transmit complete, bank 0 out, bank 1 out, setup, stall/crc.
// - an endpoint requests the usb interrupt only when its flag and enable are both set.
// - a flag clears by itself once all its sources are clear; software cannot clear it.
// - reserved bits read as zero and software must not write ones to them.
// - writing one to enable bit n enables endpoint n, zero disables, bits 0..5.
// - the crc-good bit, bit 5 of the frame high register, is set for a clean frame number.
// - the crc-bad bit, bit 4 of the frame high register, is set for a corrupted frame number.
// - both crc bits are refreshed on every start-of-frame packet.
// - the start-of-frame event fires right after the pid, before the crc check.
// - frame high bits 2..0 carry frame number bits 10..8.
// - the captured frame number is that of the latest start-of-frame packet.
// - frame high register is read only; writes do nothing.
// - frame low register is read only; writes do nothing.
module usb_endpoint_irq_frame_number
  import usb_ep_irq_pkg::*;
#(
  parameter int NUM_EP  = `NUM_ENDPOINTS,
  parameter int NUM_SRC = `NUM_SOURCES
) (
  input  wire logic                         pclk,           // core clock
  input  wire logic                         presetn,        // async reset, low
  input  wire logic                         psel,           // apb select
  input  wire logic                         penable,        // apb access phase
  input  wire logic                         pwrite,         // apb write
  input  wire logic [31:0]                  paddr,          // apb byte address
  input  wire logic [31:0]                  pwdata,         // apb write data
  output logic      [31:0]                  prdata,         // apb read data
  output logic                              pready,         // apb ready
  output logic                              pslverr,        // apb error
  input  wire logic [NUM_EP*NUM_SRC-1:0]    endpoint_sources, // per-ep source levels
  input  wire logic                         sof_pid_seen,   // pulse: sof pid received
  input  wire logic                         sof_done,       // pulse: frame number checked
  input  wire logic                         sof_crc_ok,     // crc result with sof_done
  input  wire logic [10:0]                  sof_frame,      // frame number with sof_done
  output logic                              usb_irq,        // endpoint interrupt level
  output logic                              sof_irq         // start-of-frame/crc interrupt
);

  ep_irq_state_t s_reg;
  ep_irq_state_t s_next;
  logic          pslverr_reg;
  logic          pslverr_next;

  logic [NUM_EP-1:0] ep_any;

  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] idx);
    addr_is = (a == `IDX_TO_ADDR(idx));
  endfunction : addr_is

  function automatic logic mapped(input logic [31:0] a);
    mapped = addr_is(a, `FRAME_LOW_IDX) | addr_is(a, `FRAME_HIGH_IDX) |
             addr_is(a, `EP_FLAGS_IDX) | addr_is(a, `EP_ENABLES_IDX) |
             addr_is(a, `SOF_STATUS_IDX) | addr_is(a, `SOF_MASK_IDX);
  endfunction : mapped

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      assign ep_any[g] = |endpoint_sources[g*NUM_SRC +: NUM_SRC];
    end
  endgenerate

  always_comb begin
    logic        access;
    logic        wr;
    logic        rd;
    logic [7:0]  high_byte;
    logic [1:0]  sof_evt;
    access    = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    high_byte = 8'h00;
    sof_evt   = 2'b00;
    s_next    = s_reg;
    pslverr_next = 1'b0;

    access = psel & penable & ~s_reg.pready;
    wr     = access & pwrite;
    rd     = access & ~pwrite;
    s_next.pready = access;

    // flags follow the sources: set on any, clear when all are clear
    s_next.flags = ep_any;

    if (wr && addr_is(paddr, `EP_ENABLES_IDX)) begin
      s_next.enables = pwdata[NUM_EP-1:0];
    end
    if (wr && addr_is(paddr, `SOF_MASK_IDX)) begin
      s_next.sof_mask = pwdata[1:0];
    end

    case (s_reg.sof_st)
      st_idle: begin
        if (sof_pid_seen) begin
          sof_evt[0]    = 1'b1;
          s_next.sof_st = st_wait_crc;
        end
      end
      st_wait_crc: begin
        if (sof_done) begin
          s_next.frame    = sof_frame;
          s_next.crc_good = sof_crc_ok;
          s_next.crc_bad  = ~sof_crc_ok;
          sof_evt[1]      = 1'b1;
          s_next.sof_st   = st_idle;
        end else if (sof_pid_seen) begin
          sof_evt[0] = 1'b1;
        end
      end
      default: begin
        s_next.sof_st = st_idle;
      end
    endcase

    high_byte = 8'h00;
    high_byte[`CRC_GOOD_BIT]      = s_reg.crc_good;
    high_byte[`CRC_BAD_BIT]       = s_reg.crc_bad;
    high_byte[`FRAME_HIGH_MSB:0]  = s_reg.frame[10:8];

    s_next.prdata = 32'h0000_0000;
    if (rd) begin
      if (addr_is(paddr, `FRAME_LOW_IDX)) begin
        s_next.prdata = {24'h000000, s_reg.frame[7:0]};
      end else if (addr_is(paddr, `FRAME_HIGH_IDX)) begin
        s_next.prdata = {24'h000000, high_byte};
      end else if (addr_is(paddr, `EP_FLAGS_IDX)) begin
        s_next.prdata = {26'h0000000, s_reg.flags};
      end else if (addr_is(paddr, `EP_ENABLES_IDX)) begin
        s_next.prdata = {26'h0000000, s_reg.enables};
      end else if (addr_is(paddr, `SOF_STATUS_IDX)) begin
        s_next.prdata = {30'h00000000, s_reg.sof_status};
      end else if (addr_is(paddr, `SOF_MASK_IDX)) begin
        s_next.prdata = {30'h00000000, s_reg.sof_mask};
      end
    end
    if (access && !mapped(paddr)) begin
      pslverr_next = 1'b1;
    end

    // read clears, a new event in the same cycle wins
    if (rd && addr_is(paddr, `SOF_STATUS_IDX)) begin
      s_next.sof_status = sof_evt;
    end else begin
      s_next.sof_status = s_reg.sof_status | sof_evt;
    end

    s_next.irq = |(s_next.flags & s_next.enables);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.enables    <= `ENABLES_RESET;
      s_reg.flags      <= 6'h00;
      s_reg.frame      <= 11'h000;
      s_reg.crc_good   <= 1'b0;
      s_reg.crc_bad    <= 1'b0;
      s_reg.sof_status <= 2'h0;
      s_reg.sof_mask   <= 2'h0;
      s_reg.sof_st     <= st_idle;
      s_reg.prdata     <= 32'h0000_0000;
      s_reg.pready     <= 1'b0;
      s_reg.irq        <= 1'b0;
      pslverr_reg      <= 1'b0;
      sof_irq          <= 1'b0;
    end else begin
      s_reg       <= s_next;
      pslverr_reg <= pslverr_next;
      sof_irq     <= |(s_next.sof_status & s_next.sof_mask);
    end
  end

  assign prdata  = s_reg.prdata;
  assign pready  = s_reg.pready;
  assign pslverr = pslverr_reg;
  assign usb_irq = s_reg.irq;

endmodule : usb_endpoint_irq_frame_number

// [shared/usb_ep_irq_cfg.svh]
`ifndef USB_EP_IRQ_CFG_SVH
`define USB_EP_IRQ_CFG_SVH
// register word indices (printed offsets not all multiples of four)
`define FRAME_LOW_IDX      8'hba
`define FRAME_HIGH_IDX     8'hbb
`define EP_FLAGS_IDX       8'hf8
`define EP_ENABLES_IDX     8'hf9
`define SOF_STATUS_IDX     8'hfa
`define SOF_MASK_IDX       8'hfb
`define IDX_TO_ADDR(i)     {22'h0, (i), 2'b00}
`define FRAME_HIGH_RESET   8'h00
`define FRAME_LOW_RESET    8'h00
`define ENABLES_RESET      6'h00
`define CRC_GOOD_BIT       5
`define CRC_BAD_BIT        4
`define FRAME_HIGH_MSB     2
`define NUM_ENDPOINTS      6
`define NUM_SOURCES        5
`endif

// [shared/usb_ep_irq_pkg.sv]
package usb_ep_irq_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_wait_crc
  } sof_state_t;

  typedef struct packed {
    logic [5:0]  enables;
    logic [5:0]  flags;
    logic [10:0] frame;
    logic        crc_good;
    logic        crc_bad;
    logic [1:0]  sof_status;
    logic [1:0]  sof_mask;
    sof_state_t  sof_st;
    logic [31:0] prdata;
    logic        pready;
    logic        irq;
  } ep_irq_state_t;
endpackage : usb_ep_irq_pkg
